// file: pkg/mdp_pkg.sv
// constants and types for the micro-programmed datapath
package mdp_pkg;
  localparam int unsigned SYS_CLK_MHZ  = 125;
  localparam int unsigned CYCLE_NS     = 600;
  localparam int unsigned PULSE_A_END  = 250;
  localparam int unsigned PULSE_B_BEG  = 300;
  localparam int unsigned PULSE_C_BEG  = 400;
  localparam int unsigned PULSE_C_END  = 550;
  localparam int unsigned CYC_TICKS    = CYCLE_NS * SYS_CLK_MHZ / 1000;
  localparam int unsigned A_TICKS      = PULSE_A_END * SYS_CLK_MHZ / 1000;
  localparam int unsigned B_BEG_TICKS  = (PULSE_B_BEG * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned C_BEG_TICKS  = (PULSE_C_BEG * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned C_END_TICKS  = PULSE_C_END * SYS_CLK_MHZ / 1000;
  localparam int unsigned TICK_W       = 7;
  localparam int unsigned NUM_DR       = 8;
  localparam int unsigned MA_W         = 8;
  localparam int unsigned MA_POS21     = 0;
  localparam logic [4:0]  DR_RESET     = 5'h10;
  // register select codes
  localparam logic [2:0]  DR_E = 3'h0;
  localparam logic [2:0]  DR_S = 3'h1;
  localparam logic [2:0]  DR_T = 3'h2;
  localparam logic [2:0]  DR_R = 3'h3;
  localparam logic [2:0]  DR_U = 3'h4;
  localparam logic [2:0]  DR_L = 3'h5;
  localparam logic [2:0]  DR_P = 3'h6;
  localparam logic [2:0]  DR_I = 3'h7;
  typedef enum logic [3:0] {
    OP_NOP, OP_MOVE, OP_INCR, OP_DECR, OP_OR_FORM, OP_AND_FORM, OP_XOR_FORM,
    OP_SENSE, OP_CTL15, OP_LOAD_CONST, OP_STORE, OP_FETCH, OP_IO_IN
  } op_type;
  typedef enum logic [1:0] { SRC_DR, SRC_IO, SRC_WORD } src_type;
endpackage : mdp_pkg

// file: logic/microcode_datapath.sv
// micro-programmed datapath: data registers, bus, modifier, exchange, branch forming
`timescale 1ns/10ps
module microcode_datapath (
  input  wire logic            sys_clk,          // 125 MHz clock
  input  wire logic            rst_n,            // async reset, active low
  input  wire logic            run,              // process level, cycles advance
  input  wire mdp_pkg::op_type op,               // decoded micro-order
  input  wire mdp_pkg::src_type bus_src,         // bus source select
  input  wire logic [2:0]      dr_sel,           // data register address
  input  wire logic [2:0]      dr_dst,           // modifier result destination
  input  wire logic [3:0]      word_n,           // micro-word positions 6 to 9
  input  wire logic [4:0]      io_in,            // io data with parity
  input  wire logic [3:0]      sense_bits,       // sensed conditions
  input  wire logic [4:0]      core_upper,       // fetched upper half byte
  input  wire logic [4:0]      core_lower,       // fetched lower half byte
  input  wire logic [7:0]      next_seq_micro_addr, // next sequential address
  input  wire logic            stopped_display,  // processor stopped for display
  output logic [7:0]           micro_address_reg,// micro-address, bit0 is position 21
  output logic [14:0]          storage_address_reg, // p s t r address lines
  output logic [9:0]           core_wdata,       // u and l to storage
  output logic [4:0]           bus_latch,        // bus latch contents
  output logic                 parity_err,       // modifier parity error
  output logic                 carry,            // modifier carry
  output logic                 clock_a,          // clock a pulse marker
  output logic                 clock_c,          // clock c pulse marker
  output logic                 xchg_latch,       // exchange latch
  output logic                 xchg_ilock        // exchange interlock latch
);
  import mdp_pkg::*;

  logic [TICK_W-1:0] tick_r;
  logic [4:0]        dr_r [NUM_DR];
  logic [4:0]        xreg_r [4];      // a s t r main
  logic [4:0]        sub1_r [4];
  logic [4:0]        sub2_r [4];
  logic [4:0]        bus;
  logic [4:0]        mod_out;
  logic              mod_carry;
  logic              a_edge;
  logic              c_edge;
  logic [15:0]       sar_cat;
  localparam int unsigned PIN_W = 10;
  logic [PIN_W-1:0]  pin_raw;
  logic [PIN_W-1:0]  pin_s1_r;
  logic [PIN_W-1:0]  pin_s2_r;
  logic [PIN_W-1:0]  pin_s3_r;
  logic [PIN_W-1:0]  pin_r;
  logic [4:0]        io_s;
  logic [3:0]        sense_s;
  logic              stop_s;

  function automatic logic [4:0] with_par(input logic [3:0] d);
    return {~^d, d};
  endfunction : with_par

  // micro-orders whose modifier result goes back into register dr_dst at clock c
  function automatic logic writes_back(input op_type o);
    return o inside {OP_MOVE, OP_INCR, OP_DECR, OP_IO_IN};
  endfunction : writes_back

  // 600 ns cycle counter; clock a at start, clock c at pulse c
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= '0;
    end else if (!run || tick_r == TICK_W'(CYC_TICKS - 1)) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + 1'b1;
    end
  end

  assign a_edge = run && (tick_r == '0);
  assign c_edge = run && (tick_r == TICK_W'(C_BEG_TICKS));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_a <= 1'b0;
      clock_c <= 1'b0;
    end else begin
      clock_a <= run && (tick_r < TICK_W'(A_TICKS));
      clock_c <= run && (tick_r >= TICK_W'(C_BEG_TICKS)) && (tick_r < TICK_W'(C_END_TICKS));
    end
  end

  // io, sense and console levels come from outside: three stages, and a
  // change is taken only once the second and third stages agree
  assign pin_raw = {stopped_display, sense_bits, io_in};

  generate
    for (genvar p = 0; p < PIN_W; p++) begin : g_pin
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1_r[p] <= 1'b0;
          pin_s2_r[p] <= 1'b0;
          pin_s3_r[p] <= 1'b0;
          pin_r[p]    <= 1'b0;
        end else begin
          pin_s1_r[p] <= pin_raw[p];
          pin_s2_r[p] <= pin_s1_r[p];
          pin_s3_r[p] <= pin_s2_r[p];
          if (pin_s2_r[p] == pin_s3_r[p]) pin_r[p] <= pin_s3_r[p];
        end
      end
    end
  endgenerate

  assign io_s    = pin_r[4:0];
  assign sense_s = pin_r[8:5];
  assign stop_s  = pin_r[9];

  // bus: five bits, parity checked at clock c via the modifier except on incr and decr
  always_comb begin
    unique case (bus_src)
      SRC_DR:   bus = (dr_sel == DR_S) ? xreg_r[1] :
                      (dr_sel == DR_T) ? xreg_r[2] :
                      (dr_sel == DR_R) ? xreg_r[3] : dr_r[dr_sel];
      SRC_IO:   bus = io_s;
      SRC_WORD: bus = with_par(word_n);
      default:  bus = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_latch <= DR_RESET;
    end else if (a_edge) begin
      bus_latch <= (op == OP_SENSE) ? with_par(sense_s) : bus;
    end
  end

  // modifier on the bus latch
  always_comb begin
    mod_carry = 1'b0;
    mod_out   = bus_latch;
    if (op == OP_INCR) begin
      mod_out   = with_par(bus_latch[3:0] + 4'h1);
      mod_carry = (bus_latch[3:0] == 4'hf);
    end else if (op == OP_DECR) begin
      mod_out   = with_par(bus_latch[3:0] - 4'h1);
      mod_carry = (bus_latch[3:0] == 4'h0);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      parity_err <= 1'b0;
      carry      <= 1'b0;
    end else if (c_edge) begin
      parity_err <= ~(^mod_out);
      carry      <= mod_carry;
    end
  end

  // micro-address: branch forming and carry branch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      micro_address_reg <= '0;
    end else if (a_edge) begin
      unique case (op)
        OP_OR_FORM:  micro_address_reg <= {next_seq_micro_addr[7:4],
                       next_seq_micro_addr[3:0] | bus[3:0]};
        OP_AND_FORM: micro_address_reg <= {next_seq_micro_addr[7:4],
                       next_seq_micro_addr[3:0] & bus[3:0]};
        OP_XOR_FORM: micro_address_reg <= {next_seq_micro_addr[7:4],
                       next_seq_micro_addr[3:0] ^ bus[3:0]};
        default:     micro_address_reg <= next_seq_micro_addr;
      endcase
    end else if (c_edge && mod_carry && !micro_address_reg[MA_POS21]) begin
      micro_address_reg[MA_POS21] <= 1'b1;
    end
  end

  // general data registers e u l p i
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_DR; i++) dr_r[i] <= DR_RESET;
    end else begin
      if (stop_s) dr_r[DR_E] <= xreg_r[0];
      if (a_edge && op == OP_FETCH) begin
        dr_r[DR_U] <= core_upper;
        dr_r[DR_L] <= core_lower;
      end
      if (c_edge) begin
        if (op == OP_SENSE) dr_r[DR_L] <= mod_out;
        else if (op == OP_LOAD_CONST) dr_r[DR_I] <= with_par(bus_latch[3:0]);
        else if (writes_back(op) && !(dr_dst inside {DR_S, DR_T, DR_R})
                 && !(dr_dst == DR_E && stop_s))
          dr_r[dr_dst] <= mod_out;
      end
    end
  end

  // exchange latches
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xchg_latch <= 1'b0;
      xchg_ilock <= 1'b0;
    end else begin
      if (a_edge) begin
        if (xchg_ilock) xchg_latch <= 1'b0;
        else if (op == OP_CTL15) xchg_latch <= 1'b1;
      end
      if (c_edge) begin
        if (xchg_latch) xchg_ilock <= 1'b1;
        else xchg_ilock <= 1'b0;
      end
    end
  end

  // a s t r main and sub-registers; index 0 is a
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_xreg
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          xreg_r[g] <= DR_RESET;
          sub1_r[g] <= DR_RESET;
          sub2_r[g] <= DR_RESET;
        end else begin
          if (a_edge && !xchg_ilock && op == OP_CTL15) sub1_r[g] <= xreg_r[g];
          if (c_edge && xchg_latch) begin
            xreg_r[g] <= sub2_r[g];
          end else if (c_edge && writes_back(op) && g != 0 && dr_dst == 3'(g)) begin
            xreg_r[g] <= mod_out;
          end
          if (c_edge && !xchg_latch && xchg_ilock) sub2_r[g] <= sub1_r[g];
        end
      end
    end
  endgenerate

  // storage address and write data outputs; top bit of p falls off the address
  assign sar_cat = {dr_r[DR_P][3:0], xreg_r[1][3:0], xreg_r[2][3:0], xreg_r[3][3:0]};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      storage_address_reg <= '0;
      core_wdata          <= '0;
    end else begin
      storage_address_reg <= sar_cat[14:0];
      core_wdata          <= {dr_r[DR_U], dr_r[DR_L]};
    end
  end

  a_carry_branch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (c_edge && mod_carry && !micro_address_reg[MA_POS21]) |=> micro_address_reg[MA_POS21])
    else $error("carry did not set position 21");
  a_or_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && op == OP_OR_FORM && bus[3:0] == 4'h0)
      |=> micro_address_reg == $past(next_seq_micro_addr))
    else $error("zero or changed address");
  a_xchg_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && op == OP_CTL15 && !xchg_ilock) |=> xchg_latch)
    else $error("exchange latch not set");
  a_ilock_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && xchg_ilock) |=> !xchg_latch)
    else $error("exchange latch set under interlock");
  a_ilock_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (c_edge && xchg_latch) |=> xchg_ilock && xreg_r[1] == $past(sub2_r[1]))
    else $error("clock c exchange failed");
  a_ilock_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (c_edge && !xchg_latch && xchg_ilock) |=> !xchg_ilock && sub2_r[2] == $past(sub1_r[2]))
    else $error("second cycle copy failed");
  a_incr_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (op == OP_INCR) |-> mod_out[3:0] == bus_latch[3:0] + 4'h1)
    else $error("increment wrong");
  a_mod_parity: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (c_edge && op == OP_INCR) |=> !parity_err)
    else $error("generated parity flagged");
  a_sense_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && op == OP_SENSE) ##50 (c_edge && op == OP_SENSE)
      |=> dr_r[DR_L][3:0] == $past(sense_s, 51))
    else $error("sense not in l register");

  // bus and modifier checks
  a_bus_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!a_edge) |=> $stable(bus_latch))
    else $error("bus latch changed mid cycle");
  a_bus_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && op != OP_SENSE) |=> bus_latch == $past(bus))
    else $error("bus latch missed bus value");
  a_io_path: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && op != OP_SENSE && bus_src == SRC_IO) |=> bus_latch == $past(io_s))
    else $error("io data not on bus");
  a_word_path: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && op != OP_SENSE && bus_src == SRC_WORD) |=> bus_latch[3:0] == $past(word_n))
    else $error("word field not on bus");
  a_sense_path: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && op == OP_SENSE) |=> bus_latch[3:0] == $past(sense_s))
    else $error("sensed bits not latched");
  a_decr_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (op == OP_DECR) |-> mod_out[3:0] == bus_latch[3:0] - 4'h1)
    else $error("decrement wrong");
  a_pass_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (op != OP_INCR && op != OP_DECR) |-> mod_out == bus_latch)
    else $error("modifier changed passed data");
  a_carry_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (c_edge && op == OP_DECR && bus_latch[3:0] == 4'h0) |=> carry && micro_address_reg[MA_POS21])
    else $error("decrement wrap gave no carry");

  // micro-address checks
  a_addr_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!a_edge && !(c_edge && mod_carry)) |=> micro_address_reg == $past(micro_address_reg))
    else $error("micro-address moved without cause");
  a_and_form: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && op == OP_AND_FORM) |=> micro_address_reg ==
      {$past(next_seq_micro_addr[7:4]), $past(next_seq_micro_addr[3:0] & bus[3:0])})
    else $error("and branch wrong");
  a_xor_form: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && op == OP_XOR_FORM) |=> micro_address_reg ==
      {$past(next_seq_micro_addr[7:4]), $past(next_seq_micro_addr[3:0] ^ bus[3:0])})
    else $error("xor branch wrong");

  // register checks
  a_fetch_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && op == OP_FETCH) |=> dr_r[DR_U] == $past(core_upper) && dr_r[DR_L] == $past(core_lower))
    else $error("fetched byte not in u and l");
  a_core_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> core_wdata == $past({dr_r[DR_U], dr_r[DR_L]}))
    else $error("write data not from u and l");
  a_addr_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> storage_address_reg[11:0] == $past(sar_cat[11:0]))
    else $error("storage address not from s t r");
  a_const_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (c_edge && op == OP_LOAD_CONST) |=> dr_r[DR_I][3:0] == $past(bus_latch[3:0]))
    else $error("constant not in i register");
  a_display_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stop_s |=> dr_r[DR_E] == $past(xreg_r[0]))
    else $error("e register not tracking a");

  // exchange checks
  a_sub1_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (a_edge && op == OP_CTL15 && !xchg_ilock) |=> sub1_r[3] == $past(xreg_r[3]))
    else $error("main not copied to sub1");
  a_main_swap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (c_edge && xchg_latch) |=> xreg_r[0] == $past(sub2_r[0]) && xreg_r[3] == $past(sub2_r[3]))
    else $error("sub2 not moved to main");
  a_latch_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!a_edge) |=> xchg_latch == $past(xchg_latch))
    else $error("exchange latch moved off clock a");
  a_ilock_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!c_edge) |=> xchg_ilock == $past(xchg_ilock))
    else $error("interlock moved off clock c");

  // cycle timing checks
  a_cycle_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (run && tick_r == TICK_W'(CYC_TICKS - 1)) |=> tick_r == '0)
    else $error("cycle length wrong");
  a_clock_a_win: assert property (@(posedge sys_clk) disable iff (!rst_n)
    a_edge |=> clock_a)
    else $error("clock a missing");
  a_clock_c_win: assert property (@(posedge sys_clk) disable iff (!rst_n)
    c_edge |=> clock_c && !clock_a)
    else $error("clock c missing");
endmodule : microcode_datapath

// file: bench/test_microcode_datapath.sv
// self-checking bench for the micro-programmed datapath
`timescale 1ns/10ps
module test_microcode_datapath;
  import mdp_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        run = 1'b0;
  op_type      op = OP_NOP;
  src_type     bus_src = SRC_WORD;
  logic [2:0]  dr_sel = 3'h0;
  logic [2:0]  dr_dst = 3'h0;
  logic [3:0]  word_n = 4'h0;
  logic [4:0]  io_in = 5'h10;
  logic [3:0]  sense_bits = 4'h0;
  logic [4:0]  core_upper = 5'h13;
  logic [4:0]  core_lower = 5'h1c;
  logic [7:0]  next_seq_micro_addr = 8'h00;
  logic        stopped_display = 1'b0;
  logic [7:0]  micro_address_reg;
  logic [14:0] storage_address_reg;
  logic [9:0]  core_wdata;
  logic [4:0]  bus_latch;
  logic        parity_err, carry, clock_a, clock_c, xchg_latch, xchg_ilock;
  int          mismatches = 0;
  int          comparisons = 0;
  microcode_datapath u_microcode_datapath (.sys_clk(sys_clk), .rst_n(rst_n), .run(run),
    .op(op), .bus_src(bus_src), .dr_sel(dr_sel), .dr_dst(dr_dst), .word_n(word_n),
    .io_in(io_in), .sense_bits(sense_bits), .core_upper(core_upper), .core_lower(core_lower),
    .next_seq_micro_addr(next_seq_micro_addr), .stopped_display(stopped_display),
    .micro_address_reg(micro_address_reg), .storage_address_reg(storage_address_reg),
    .core_wdata(core_wdata), .bus_latch(bus_latch), .parity_err(parity_err), .carry(carry),
    .clock_a(clock_a), .clock_c(clock_c), .xchg_latch(xchg_latch), .xchg_ilock(xchg_ilock));
  always #4 sys_clk = ~sys_clk;
  function automatic logic [4:0] par(input logic [3:0] d);
    return {~^d, d};
  endfunction : par
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // waits until the clock a or clock c window has come and gone
  task automatic wait_fall(input bit on_c);
    int n;
    bit hi;
    hi = 1'b0;
    for (n = 0; n < 160; n++) begin
      @(posedge sys_clk);
      #1;
      if (on_c ? clock_c : clock_a) hi = 1'b1;
      else if (hi) break;
    end
    if (n == 160) mismatches++;
  endtask : wait_fall
  // new micro-order goes in after clock c, ahead of the next clock a
  task automatic issue(input op_type o, input src_type s, input logic [2:0] sel,
                       input logic [2:0] dst, input logic [3:0] w);
    @(posedge sys_clk);
    op <= o;
    bus_src <= s;
    dr_sel <= sel;
    dr_dst <= dst;
    word_n <= w;
    wait_fall(1'b0);
  endtask : issue
  task automatic cyc(input op_type o, input src_type s, input logic [2:0] sel,
                     input logic [2:0] dst, input logic [3:0] w);
    issue(o, s, sel, dst, w);
    wait_fall(1'b1);
  endtask : cyc
  task automatic peek(input logic [2:0] sel, input logic [3:0] v);
    cyc(OP_MOVE, SRC_DR, sel, DR_U, 4'h0);
    check(core_wdata[9:5], par(v));
  endtask : peek
  task automatic t_timing;
    int hi_a;
    int hi_c;
    hi_a = 0;
    hi_c = 0;
    for (int n = 0; n < CYC_TICKS; n++) begin
      @(posedge sys_clk);
      #1;
      hi_a += int'(clock_a);
      hi_c += int'(clock_c);
    end
    check(15'(hi_a), 15'(A_TICKS));
    check(15'(hi_c), 15'(C_END_TICKS - C_BEG_TICKS));
    $display("timing test done");
  endtask : t_timing
  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      cyc(OP_MOVE, SRC_WORD, 3'(i), 3'(i), 4'(i + 8));
      peek(3'(i), 4'(i + 8));
    end
    cyc(OP_LOAD_CONST, SRC_WORD, DR_I, DR_I, 4'h7);
    peek(DR_I, 4'h7);
    cyc(OP_MOVE, SRC_WORD, 3'h0, DR_S, 4'h9);
    cyc(OP_MOVE, SRC_WORD, 3'h0, DR_T, 4'ha);
    cyc(OP_MOVE, SRC_WORD, 3'h0, DR_R, 4'h5);
    check(storage_address_reg, {3'h6, 4'h9, 4'ha, 4'h5});
    $display("registers test done");
  endtask : t_regs
  task automatic t_modify;
    op_type     ops [4] = '{OP_INCR, OP_DECR, OP_INCR, OP_DECR};
    logic [3:0] vin [4] = '{4'hf, 4'h0, 4'h5, 4'h9};
    for (int i = 0; i < 4; i++) begin
      cyc(OP_MOVE, SRC_WORD, 3'h0, DR_L, vin[i]);
      cyc(ops[i], SRC_DR, DR_L, DR_L, 4'h0);
      check(carry, i < 2);
      if (i < 2) check(micro_address_reg[MA_POS21], 1'b1);
      check(parity_err, 1'b0);
      peek(DR_L, ops[i] == OP_INCR ? vin[i] + 4'h1 : vin[i] - 4'h1);
    end
    $display("modifier test done");
  endtask : t_modify
  task automatic t_branch;
    op_type     ops [4] = '{OP_OR_FORM, OP_OR_FORM, OP_AND_FORM, OP_XOR_FORM};
    logic [3:0] v [4] = '{4'h3, 4'h0, 4'hb, 4'hb};
    logic [3:0] m [4] = '{4'h0, 4'h0, 4'hc, 4'hc};
    logic [3:0] e;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      next_seq_micro_addr <= {4'h8, m[i]};
      cyc(OP_MOVE, SRC_WORD, 3'h0, DR_L, v[i]);
      cyc(ops[i], SRC_DR, DR_L, DR_P, 4'h0);
      e = (i < 2) ? (m[i] | v[i]) : (i == 2) ? (m[i] & v[i]) : (m[i] ^ v[i]);
      check(micro_address_reg, {4'h8, e});
    end
    $display("branch test done");
  endtask : t_branch
  task automatic t_io;
    @(posedge sys_clk);
    sense_bits <= 4'ha;
    io_in <= 5'h03;
    cyc(OP_SENSE, SRC_IO, 3'h0, DR_L, 4'h0);
    check(core_wdata[4:0], par(4'ha));
    cyc(OP_MOVE, SRC_IO, 3'h0, DR_P, 4'h0);
    check(bus_latch, 5'h03);
    check(parity_err, 1'b1);
    cyc(OP_FETCH, SRC_DR, DR_S, DR_U, 4'h0);
    check(core_wdata, {core_upper, core_lower});
    $display("sense and io test done");
  endtask : t_io
  task automatic t_xchg;
    cyc(OP_MOVE, SRC_WORD, 3'h0, DR_S, 4'h9);
    issue(OP_CTL15, SRC_DR, 3'h0, 3'h0, 4'h0);
    check({xchg_latch, xchg_ilock}, 2'b10);
    wait_fall(1'b1);
    check({xchg_latch, xchg_ilock}, 2'b11);
    issue(OP_NOP, SRC_DR, 3'h0, 3'h0, 4'h0);
    check({xchg_latch, xchg_ilock}, 2'b01);
    wait_fall(1'b1);
    check({xchg_latch, xchg_ilock}, 2'b00);
    cyc(OP_CTL15, SRC_DR, 3'h0, 3'h0, 4'h0);
    check(storage_address_reg[11:8], 4'h9);
    issue(OP_CTL15, SRC_DR, 3'h0, 3'h0, 4'h0);
    check(xchg_latch, 1'b0);
    wait_fall(1'b1);
    check({xchg_latch, xchg_ilock, storage_address_reg[11:8]}, {2'b00, 4'h9});
    $display("exchange test done");
  endtask : t_xchg
  task automatic t_display;
    @(posedge sys_clk);
    stopped_display <= 1'b1;
    cyc(OP_NOP, SRC_DR, DR_E, DR_E, 4'h0);
    peek(DR_E, 4'h0);
    @(posedge sys_clk);
    stopped_display <= 1'b0;
    $display("display test done");
  endtask : t_display
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    check({bus_latch, xchg_latch, xchg_ilock, carry}, {5'h10, 3'b000});
    @(posedge sys_clk);
    run <= 1'b1;
    wait_fall(1'b1);
    t_timing();
    t_regs();
    t_modify();
    t_branch();
    t_io();
    t_xchg();
    t_display();
    test_done();
  end
endmodule : test_microcode_datapath
